// File: gpm_pkg.sv
// Constants for the pin function multiplexer and edge detector.
// Assumes one 200 MHz clock and a byte-addressed Avalon-MM slave port.
package gpm_pkg;
    localparam int ADDR_W = 18;
    localparam int NUM_PINS = 8;
    localparam int PWM_W = 11;
    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_RISE0 = 16'hA028;
    localparam logic [15:0] IDX_RISE1 = 16'hA029;
    localparam logic [15:0] IDX_IRQ_CTRL = 16'hA02C;
    localparam logic [15:0] IDX_FALL0 = 16'hA038;
    localparam logic [15:0] IDX_P1_4 = 16'hA05C;
    localparam logic [15:0] IDX_P1_5 = 16'hA05D;
    localparam logic [15:0] IDX_P1_6 = 16'hA05E;
    localparam logic [15:0] IDX_P1_7 = 16'hA05F;
    localparam logic [15:0] IDX_P2_0 = 16'hA070;
    localparam logic [15:0] IDX_P2_1 = 16'hA071;
    localparam logic [15:0] IDX_P2_2 = 16'hA072;
    localparam logic [15:0] IDX_P2_3 = 16'hA073;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    // Field positions in a pin function register
    localparam logic [2:0] BIT_GPIO = 3'h0;
    localparam logic [2:0] BIT_GRP0 = 3'h1;
    localparam logic [2:0] BIT_TIMER = 3'h1;
    localparam logic [2:0] BIT_GRP1 = 3'h2;
    localparam logic [2:0] BIT_SPI = 3'h3;
    localparam logic [2:0] BIT_BUZ = 3'h4;
    localparam logic [2:0] BIT_ALT5 = 3'h5;
    localparam logic [2:0] BIT_ALT6 = 3'h6;
    localparam logic [2:0] BIT_PWM = 3'h7;
    // Pin slots: 0..3 are P1.4..P1.7, 4..7 are P2.0..P2.3
    localparam logic [7:0][7:0] FN_VALID = 64'hE8E8F8F8E0E8E8F8;
    localparam logic [7:0][3:0] PWM_MAP = 32'h5432A987;
endpackage

// File: gpm_pin_mux.sv
// Pin function multiplexer for P1.4-P1.7 and P2.0-P2.3 with edge latches.
// Assumes pads outside resolve pad_out/pad_oe_n; pin inputs are asynchronous.
//
// The Avalon-MM slave port is this design's own decision.
module gpm_pin_mux (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire logic [gpm_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Pins
    input wire logic [7:0] port0_pin_in,
    input wire logic [7:0] port1_pin_in,
    input wire logic [3:0] port2_pin_in,
    output logic [7:0] pad_out,
    output logic [7:0] pad_oe_n,
    // Plain I/O core side
    input wire logic [7:0] gpio_out,
    input wire logic [7:0] gpio_oe_n,
    output logic [7:0] gpio_in,
    // Peripheral outputs to route
    input wire logic [gpm_pkg::PWM_W-1:0] pwm_out,
    input wire logic buzzer_out,
    input wire logic i2c_master_sda_low,
    input wire logic i2c_master_scl_low,
    input wire logic i2c_slave_b_sda_low,
    input wire logic i2c_slave_b_scl_low,
    input wire logic spi_miso_out,
    input wire logic spi_miso_oe_n,
    input wire logic spi_sck_out,
    input wire logic spi_sck_oe_n,
    input wire logic spi_mosi_out,
    input wire logic spi_mosi_oe_n,
    input wire logic enh_uart_tx,
    input wire logic base_uart_tx,
    // Peripheral inputs
    output logic i2c_master_sda_in,
    output logic i2c_master_scl_in,
    output logic i2c_slave_b_sda_in,
    output logic i2c_slave_b_scl_in,
    output logic spi_miso_in,
    output logic spi_sck_in,
    output logic spi_mosi_in,
    output logic spi_ssn_in,
    output logic enh_uart_rx,
    output logic base_uart_rx,
    output logic timer_a_in,
    output logic timer_b_in,
    output logic timer_c_in,
    output logic timer_c_ext_in,
    // Interrupt and wake
    output logic pin_irq_group0,
    output logic pin_irq_group1,
    output logic pin_irq,
    output logic wake_event
);
    import gpm_pkg::*;

    logic [7:0] cfg [NUM_PINS];
    logic [7:0] rise_en0, rise_en1, fall_en0;
    logic [7:0] rise_st0, rise_st1, fall_st0;
    logic [1:0] irq_en;
    logic [7:0] p0_s1, p0_s2, p0_s3, p1_s1, p1_s2, p1_s3;
    logic [3:0] p2_s1, p2_s2;
    logic [7:0] mux_sync;
    logic [7:0] rise0_evt, rise1_evt, fall0_evt;
    logic [7:0] next_rise_st0, next_rise_st1, next_fall_st0;
    logic wr_ok, wr_rise0, wr_rise1, wr_fall0;
    logic [7:0] wdata;
    logic [7:0] next_pad_out, next_pad_oe_n;
    logic next_m_sda, next_m_scl, next_s_sda, next_s_scl;
    logic next_miso, next_sck, next_mosi, next_ssn, next_enh_rx, next_base_rx;
    logic next_tmr_a, next_tmr_b, next_tmr_c, next_tmr_cx, next_grp0, next_grp1;
    logic [2:0] fn;
    logic [7:0] rdata;

    // Address match on an aligned word
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
        return a == {idx, 2'b00};
    endfunction

    // Highest valid function bit among 7..3, else 0
    function automatic logic [2:0] pick(input logic [7:0] c, input logic [7:0] v);
        logic [2:0] r;
        r = BIT_GPIO;
        for (int b = 3; b < 8; b++) begin
            if (c[b] && v[b]) begin
                r = 3'(b);
            end
        end
        return r;
    endfunction

    // Slot index of a pin function register, or -1
    function automatic int slot(input logic [ADDR_W-1:0] a);
        int s;
        s = -1;
        if (hit(a, IDX_P1_4)) s = 0;
        if (hit(a, IDX_P1_5)) s = 1;
        if (hit(a, IDX_P1_6)) s = 2;
        if (hit(a, IDX_P1_7)) s = 3;
        if (hit(a, IDX_P2_0)) s = 4;
        if (hit(a, IDX_P2_1)) s = 5;
        if (hit(a, IDX_P2_2)) s = 6;
        if (hit(a, IDX_P2_3)) s = 7;
        return s;
    endfunction

    // Write strobe: the edge where the master sees waitrequest low
    assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign wdata = avs_writedata[7:0];
    assign wr_rise0 = wr_ok && hit(avs_address, IDX_RISE0);
    assign wr_rise1 = wr_ok && hit(avs_address, IDX_RISE1);
    assign wr_fall0 = wr_ok && hit(avs_address, IDX_FALL0);

    // Bus handshake: one wait cycle, then a one-cycle answer
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
        end
    end

    // Read mux; unmapped addresses read zero, status instead of enables
    always_comb begin
        rdata = REG_RESET;
        if (hit(avs_address, IDX_RISE0)) rdata = rise_st0;
        if (hit(avs_address, IDX_RISE1)) rdata = rise_st1;
        if (hit(avs_address, IDX_FALL0)) rdata = fall_st0;
        if (hit(avs_address, IDX_IRQ_CTRL)) rdata = {6'h00, irq_en};
        if (slot(avs_address) >= 0) rdata = cfg[slot(avs_address)];
    end

    // Read data captured while waitrequest is high, stands in the answer cycle
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= {24'h000000, rdata};
        end
    end

    // Pin function registers, all reset to zero
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            for (int i = 0; i < NUM_PINS; i++) cfg[i] <= REG_RESET;
        end else if (wr_ok && slot(avs_address) >= 0) begin
            cfg[slot(avs_address)] <= wdata;
        end
    end

    // Edge enables and port interrupt enables
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rise_en0 <= REG_RESET;
            rise_en1 <= REG_RESET;
            fall_en0 <= REG_RESET;
            irq_en <= IRQ_RESET;
        end else begin
            if (wr_rise0) rise_en0 <= wdata;
            if (wr_rise1) rise_en1 <= wdata;
            if (wr_fall0) fall_en0 <= wdata;
            if (wr_ok && hit(avs_address, IDX_IRQ_CTRL)) irq_en <= wdata[1:0];
        end
    end

    // Two-stage synchronisers plus a previous-sample stage for edges
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            {p0_s1, p0_s2, p0_s3} <= 24'h000000;
            {p1_s1, p1_s2, p1_s3} <= 24'h000000;
            {p2_s1, p2_s2} <= 8'h00;
        end else begin
            p0_s1 <= port0_pin_in;
            p0_s2 <= p0_s1;
            p0_s3 <= p0_s2;
            p1_s1 <= port1_pin_in;
            p1_s2 <= p1_s1;
            p1_s3 <= p1_s2;
            p2_s1 <= port2_pin_in;
            p2_s2 <= p2_s1;
        end
    end

    assign mux_sync = {p2_s2, p1_s2[7:4]};
    // Rising detectors on ports 0 and 1, a falling detector on port 0 only
    assign rise0_evt = p0_s2 & ~p0_s3 & rise_en0;
    assign rise1_evt = p1_s2 & ~p1_s3 & rise_en1;
    assign fall0_evt = ~p0_s2 & p0_s3 & fall_en0;

    // Clear by writing a zero enable; a same-cycle event wins over the clear
    always_comb begin
        next_rise_st0 = rise_st0;
        next_rise_st1 = rise_st1;
        next_fall_st0 = fall_st0;
        if (wr_rise0) next_rise_st0 = rise_st0 & wdata;
        if (wr_rise1) next_rise_st1 = rise_st1 & wdata;
        if (wr_fall0) next_fall_st0 = fall_st0 & wdata;
        next_rise_st0 = next_rise_st0 | rise0_evt;
        next_rise_st1 = next_rise_st1 | rise1_evt;
        next_fall_st0 = next_fall_st0 | fall0_evt;
    end

    // Status latches, interrupt and wake all move on the same edge
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rise_st0 <= REG_RESET;
            rise_st1 <= REG_RESET;
            fall_st0 <= REG_RESET;
            pin_irq <= 1'b0;
            wake_event <= 1'b0;
        end else begin
            rise_st0 <= next_rise_st0;
            rise_st1 <= next_rise_st1;
            fall_st0 <= next_fall_st0;
            pin_irq <= (irq_en[0] && |(next_rise_st0 | next_fall_st0))
                || (irq_en[1] && |next_rise_st1);
            wake_event <= |(rise0_evt | rise1_evt | fall0_evt);
        end
    end

    // Pad drive and peripheral input routing; open-drain pins only pull low
    always_comb begin
        next_pad_out = 8'hFF;
        next_pad_oe_n = 8'hFF;
        {next_m_sda, next_m_scl, next_s_sda, next_s_scl} = 4'hF;
        {next_ssn, next_enh_rx, next_base_rx} = 3'h7;
        {next_miso, next_sck, next_mosi} = 3'h0;
        {next_tmr_a, next_tmr_b, next_tmr_c, next_tmr_cx} = 4'h0;
        next_grp0 = 1'b0;
        next_grp1 = 1'b0;
        fn = BIT_GPIO;
        for (int i = 0; i < NUM_PINS; i++) begin
            fn = pick(cfg[i], FN_VALID[i]);
            case (fn)
                BIT_PWM: begin
                    next_pad_out[i] = pwm_out[PWM_MAP[i]];
                    next_pad_oe_n[i] = 1'b0;
                end
                BIT_ALT6: begin
                    case (i % 4)
                        0: begin
                            next_pad_out[i] = 1'b0;
                            next_pad_oe_n[i] = !i2c_master_sda_low;
                            next_m_sda = next_m_sda & mux_sync[i];
                        end
                        1: begin
                            next_pad_out[i] = 1'b0;
                            next_pad_oe_n[i] = !i2c_master_scl_low;
                            next_m_scl = next_m_scl & mux_sync[i];
                        end
                        2: next_enh_rx = next_enh_rx & mux_sync[i];
                        default: begin
                            next_pad_out[i] = enh_uart_tx;
                            next_pad_oe_n[i] = 1'b0;
                        end
                    endcase
                end
                BIT_ALT5: begin
                    case (i % 4)
                        0: begin
                            next_pad_out[i] = 1'b0;
                            next_pad_oe_n[i] = !i2c_slave_b_sda_low;
                            next_s_sda = next_s_sda & mux_sync[i];
                        end
                        1: begin
                            next_pad_out[i] = 1'b0;
                            next_pad_oe_n[i] = !i2c_slave_b_scl_low;
                            next_s_scl = next_s_scl & mux_sync[i];
                        end
                        2: next_base_rx = next_base_rx & mux_sync[i];
                        default: begin
                            next_pad_out[i] = base_uart_tx;
                            next_pad_oe_n[i] = 1'b0;
                        end
                    endcase
                end
                BIT_BUZ: begin
                    next_pad_out[i] = buzzer_out;
                    next_pad_oe_n[i] = 1'b0;
                end
                BIT_SPI: begin
                    case (i % 4)
                        0: begin
                            next_pad_out[i] = spi_miso_out;
                            next_pad_oe_n[i] = spi_miso_oe_n;
                            next_miso = next_miso | mux_sync[i];
                        end
                        1: begin
                            next_pad_out[i] = spi_sck_out;
                            next_pad_oe_n[i] = spi_sck_oe_n;
                            next_sck = next_sck | mux_sync[i];
                        end
                        2: begin
                            next_pad_out[i] = spi_mosi_out;
                            next_pad_oe_n[i] = spi_mosi_oe_n;
                            next_mosi = next_mosi | mux_sync[i];
                        end
                        default: next_ssn = next_ssn & mux_sync[i];
                    endcase
                end
                default: begin
                    // Timer inputs rank below 7..3; bit 2 on port 2 is unused
                    if (i >= 4 && cfg[i][BIT_TIMER]) begin
                        case (i)
                            4: next_tmr_b = mux_sync[i];
                            5: next_tmr_c = mux_sync[i];
                            6: next_tmr_cx = mux_sync[i];
                            default: next_tmr_a = mux_sync[i];
                        endcase
                    end
                    if (cfg[i][BIT_GPIO]) begin
                        next_pad_out[i] = gpio_out[i];
                        next_pad_oe_n[i] = gpio_oe_n[i];
                    end
                end
            endcase
            // Group selects sit beside any function, so several pins OR together
            if (i < 4) begin
                next_grp0 = next_grp0 | (cfg[i][BIT_GRP0] & mux_sync[i]);
                next_grp1 = next_grp1 | (cfg[i][BIT_GRP1] & mux_sync[i]);
            end
        end
    end

    // Registered pads and peripheral inputs; pads released during reset
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pad_out <= 8'hFF;
            pad_oe_n <= 8'hFF;
            gpio_in <= 8'h00;
            {i2c_master_sda_in, i2c_master_scl_in} <= 2'h3;
            {i2c_slave_b_sda_in, i2c_slave_b_scl_in} <= 2'h3;
            {spi_ssn_in, enh_uart_rx, base_uart_rx} <= 3'h7;
            {spi_miso_in, spi_sck_in, spi_mosi_in} <= 3'h0;
            {timer_a_in, timer_b_in, timer_c_in, timer_c_ext_in} <= 4'h0;
            pin_irq_group0 <= 1'b0;
            pin_irq_group1 <= 1'b0;
        end else begin
            pad_out <= next_pad_out;
            pad_oe_n <= next_pad_oe_n;
            gpio_in <= mux_sync;
            {i2c_master_sda_in, i2c_master_scl_in} <= {next_m_sda, next_m_scl};
            {i2c_slave_b_sda_in, i2c_slave_b_scl_in} <= {next_s_sda, next_s_scl};
            {spi_ssn_in, enh_uart_rx, base_uart_rx} <= {next_ssn, next_enh_rx, next_base_rx};
            {spi_miso_in, spi_sck_in, spi_mosi_in} <= {next_miso, next_sck, next_mosi};
            {timer_a_in, timer_b_in, timer_c_in, timer_c_ext_in} <=
                {next_tmr_a, next_tmr_b, next_tmr_c, next_tmr_cx};
            pin_irq_group0 <= next_grp0;
            pin_irq_group1 <= next_grp1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    a_gpio_drive: assert property (cfg[0] == 8'h01 |=>
        pad_out[0] == $past(gpio_out[0]) && pad_oe_n[0] == $past(gpio_oe_n[0]))
        else $error("plain io not driven");
    a_group_both: assert property (cfg[2][BIT_GRP0] && cfg[2][BIT_GRP1] && mux_sync[2]
        |=> pin_irq_group0 && pin_irq_group1) else $error("pin missing from a group");
    a_group0_or: assert property (cfg[2][BIT_GRP0] && mux_sync[2] |=> pin_irq_group0)
        else $error("group 0 condition lost");
    a_slave_sda: assert property (pick(cfg[4], FN_VALID[4]) == BIT_ALT5
        && i2c_slave_b_sda_low |=> !pad_oe_n[4] && !pad_out[4]) else $error("slave data not low");
    a_pwm_map: assert property (cfg[3][BIT_PWM] |=>
        pad_out[3] == $past(pwm_out[10]) && !pad_oe_n[3]) else $error("pwm map wrong");
    a_buzzer_route: assert property (pick(cfg[5], FN_VALID[5]) == BIT_BUZ
        |=> pad_out[5] == $past(buzzer_out)) else $error("buzzer not routed");
    a_spi_ssn: assert property (pick(cfg[7], FN_VALID[7]) == BIT_SPI
        |=> spi_ssn_in == $past(mux_sync[7])) else $error("ssn not routed");
    a_uart_rx: assert property (pick(cfg[2], FN_VALID[2]) == BIT_ALT6
        |=> enh_uart_rx == $past(mux_sync[2])) else $error("uart rx not routed");
    a_timer_route: assert property (cfg[4] == 8'h02
        |=> timer_b_in == $past(mux_sync[4])) else $error("timer input wrong");
    a_rise_set: assert property (rise_en1[0] && p1_s2[0] && !p1_s3[0]
        |=> rise_st1[0] ##1 rise_st1[0] || $past(wr_rise1)) else $error("rise not latched");
    a_fall_set: assert property ($fell(p0_s2[7]) && fall_en0[7] |=> fall_st0[7])
        else $error("fall not latched");
    a_status_hold: assert property (rise_st0[0] && !wr_rise0 |=> rise_st0[0])
        else $error("status lost");
    a_irq_raise: assert property (rise_st0[0] && irq_en[0] && $past(irq_en[0]) |-> pin_irq)
        else $error("irq missing");
    a_wake_pulse: assert property (rise_en0[0] && p0_s2[0] && !p0_s3[0]
        |=> wake_event && rise_st0[0]) else $error("wake missing");
    a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer late");
endmodule

// File: gpm_far_side.sv
// Far-side pad model for the eight muxed pins P1.4-P1.7 and P2.0-P2.3.
// Assumes pad_oe_n low means the block drives; ext_low pulls a pad down.
module gpm_far_side (
    // Block pads
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe_n,
    // Outside world
    input wire logic [7:0] ext_low,
    output logic [7:0] pin_lvl
);
    timeunit 1ns;
    timeprecision 100ps;
    // Wired-AND with board pull-ups, so a released open-drain pad reads high
    assign pin_lvl = (pad_oe_n | pad_out) & ~ext_low;
endmodule

// File: tb_gpio_pin_mux_edge_detect.sv
// Self-checking bench for the pin function mux and edge latches.
// Assumes gpm_pkg, the mux and the far-side pad model are compiled first.
module tb_gpio_pin_mux_edge_detect import gpm_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {logic [15:0] idx; logic [7:0] cfg; int slot; logic out; logic oe_n;} gpm_row_t;
    // Function bit, slot and expected pad drive for fixed peripheral levels
    localparam gpm_row_t ROWS [21] = '{
        '{IDX_P1_4, 8'h80, 0, 1, 0}, '{IDX_P1_5, 8'h80, 1, 0, 0}, '{IDX_P1_6, 8'h80, 2, 1, 0},
        '{IDX_P1_7, 8'h80, 3, 0, 0}, '{IDX_P2_0, 8'h80, 4, 1, 0}, '{IDX_P2_1, 8'h80, 5, 0, 0},
        '{IDX_P2_2, 8'h80, 6, 0, 0}, '{IDX_P2_3, 8'h80, 7, 1, 0}, '{IDX_P1_4, 8'h10, 0, 0, 0},
        '{IDX_P2_1, 8'h10, 5, 0, 0}, '{IDX_P1_4, 8'h08, 0, 1, 0}, '{IDX_P2_2, 8'h08, 6, 0, 0},
        '{IDX_P1_7, 8'h40, 3, 0, 0}, '{IDX_P2_3, 8'h20, 7, 1, 0}, '{IDX_P1_4, 8'h40, 0, 0, 0},
        '{IDX_P2_0, 8'h20, 4, 0, 0}, '{IDX_P1_5, 8'h01, 1, 1, 0}, '{IDX_P1_6, 8'h01, 2, 0, 0},
        '{IDX_P1_4, 8'h91, 0, 1, 0}, '{IDX_P1_6, 8'h40, 2, 1, 1}, '{IDX_P2_3, 8'h08, 7, 1, 1}};
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [7:0] p0 = 8'h00;
    logic [3:0] p1_lo = 4'h0;
    logic [7:0] ext_low = 8'h00;
    // Core-side and peripheral drive levels that fix each row's answer
    logic [3:0] byte_en = 4'hF;
    logic [7:0] gp_out = 8'h5A;
    logic [7:0] gp_oe_n = 8'h00;
    logic [7:0] gp_in;
    logic [10:0] pwm = 11'h2A5;
    // Bits: buzzer, i2c master sda/scl low, slave sda/scl low, spi miso/sck/mosi
    // out and oe_n pairs, then enhanced and base uart transmit
    logic [12:0] drv = 13'h102A;
    logic [7:0] pin_lvl, pad_out, pad_oe_n, rd;
    logic pin_irq, wake_event, grp0, grp1, timer_b;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;
    int wakes = 0;
    always #2.5 clock = ~clock;
    // Pads and peripherals held at fixed levels so each row has one answer
    gpm_pin_mux uut (.clock(clock), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(byte_en),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .port0_pin_in(p0), .port1_pin_in({pin_lvl[3:0], p1_lo}),
        .port2_pin_in(pin_lvl[7:4]), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .gpio_out(gp_out), .gpio_oe_n(gp_oe_n), .gpio_in(gp_in), .pwm_out(pwm),
        .buzzer_out(drv[0]), .i2c_master_sda_low(drv[1]), .i2c_master_scl_low(drv[2]),
        .i2c_slave_b_sda_low(drv[3]), .i2c_slave_b_scl_low(drv[4]), .spi_miso_out(drv[5]),
        .spi_miso_oe_n(drv[6]), .spi_sck_out(drv[7]), .spi_sck_oe_n(drv[8]),
        .spi_mosi_out(drv[9]), .spi_mosi_oe_n(drv[10]), .enh_uart_tx(drv[11]),
        .base_uart_tx(drv[12]), .i2c_master_sda_in(), .i2c_master_scl_in(),
        .i2c_slave_b_sda_in(), .i2c_slave_b_scl_in(), .spi_miso_in(), .spi_sck_in(),
        .spi_mosi_in(), .spi_ssn_in(), .enh_uart_rx(), .base_uart_rx(), .timer_a_in(),
        .timer_b_in(timer_b), .timer_c_in(), .timer_c_ext_in(), .pin_irq_group0(grp0),
        .pin_irq_group1(grp1), .pin_irq(pin_irq), .wake_event(wake_event));
    gpm_far_side far (.pad_out(pad_out), .pad_oe_n(pad_oe_n), .ext_low(ext_low),
        .pin_lvl(pin_lvl));
    // Count wake pulses and cut a hang short well past the expected run
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (wake_event === 1'b1) wakes <= wakes + 1;
        if (cyc == 5000) begin
            n_errors++;
            final_report();
        end
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One Avalon transfer; the request stands until waitrequest is seen low
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge clock);
        avs_address <= {idx, 2'b00};
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= {24'h0, d};
        @(posedge clock);
        while (avs_waitrequest !== 1'b0) @(posedge clock);
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // Let registered outputs settle, then sample away from the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        bus(1'b0, IDX_P2_3, 8'h00, rd);
        check("p2_3 reset", rd, REG_RESET);
        check("pads released", pad_oe_n, 8'hFF);
        bus(1'b0, 16'hA03F, 8'h00, rd);
        check("unmapped read", rd, 8'h00);
        bus(1'b1, IDX_P2_3, 8'h24, rd);
        bus(1'b0, IDX_P2_3, 8'h00, rd);
        check("p2_3 readback", rd, 8'h24);
        bus(1'b1, IDX_P2_3, 8'h00, rd);
        // A write without byte lane 0 must leave the register alone
        byte_en <= 4'hE;
        bus(1'b1, IDX_P2_3, 8'h55, rd);
        byte_en <= 4'hF;
        bus(1'b0, IDX_P2_3, 8'h00, rd);
        check("lane 0 off", rd, REG_RESET);
        $display("test registers done");
        // Each row selects one function, checks the pad, then restores
        foreach (ROWS[i]) begin
            bus(1'b1, ROWS[i].idx, ROWS[i].cfg, rd);
            tick(3);
            check("pad_out", pad_out[ROWS[i].slot], ROWS[i].out);
            check("pad_oe_n", pad_oe_n[ROWS[i].slot], ROWS[i].oe_n);
            bus(1'b1, ROWS[i].idx, REG_RESET, rd);
        end
        tick(3);
        check("pads idle", pad_oe_n, 8'hFF);
        $display("test mux rows done");
        // One pin in both groups, and a timer input, followed through the pads
        bus(1'b1, IDX_P1_6, 8'h06, rd);
        bus(1'b1, IDX_P2_0, 8'h02, rd);
        tick(4);
        check("groups high", {grp1, grp0}, 8'h03);
        check("timer high", timer_b, 8'h01);
        check("levels high", gp_in, 8'hFF);
        @(posedge clock);
        ext_low <= 8'h14;
        tick(4);
        check("groups low", {grp1, grp0}, 8'h00);
        check("timer low", timer_b, 8'h00);
        check("levels low", gp_in, 8'hEB);
        $display("test inputs done");
        // Edges: enabled bits latch, a disabled pin toggles without effect
        bus(1'b1, IDX_RISE0, 8'h01, rd);
        bus(1'b1, IDX_FALL0, 8'h80, rd);
        bus(1'b1, IDX_RISE1, 8'h01, rd);
        bus(1'b1, IDX_IRQ_CTRL, 8'h01, rd);
        @(posedge clock);
        p0 <= 8'h83;
        p1_lo <= 4'h1;
        tick(6);
        p0 <= 8'h02;
        tick(6);
        bus(1'b0, IDX_RISE0, 8'h00, rd);
        check("rise0 status", rd, 8'h01);
        bus(1'b0, IDX_FALL0, 8'h00, rd);
        check("fall0 status", rd, 8'h80);
        bus(1'b0, IDX_RISE1, 8'h00, rd);
        check("rise1 status", rd, 8'h01);
        check("pin irq", pin_irq, 8'h01);
        check("wake pulses", wakes[7:0], 8'h02);
        bus(1'b1, IDX_RISE0, 8'h00, rd);
        bus(1'b1, IDX_FALL0, 8'h00, rd);
        bus(1'b0, IDX_RISE0, 8'h00, rd);
        check("rise0 cleared", rd, 8'h00);
        tick(2);
        check("pin irq off", pin_irq, 8'h00);
        $display("test edges done");
        // Reset in mid-run puts registers and pads back to their idle values
        bus(1'b1, IDX_P1_5, 8'h01, rd);
        reset_n <= 1'b0;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        bus(1'b0, IDX_P1_5, 8'h00, rd);
        check("p1_5 after reset", rd, REG_RESET);
        check("pads after reset", pad_oe_n, 8'hFF);
        $display("test reset done");
        final_report();
    end
endmodule
